// ### inc/agcd_defs.vh
// Register map, field positions, reset values and decode tables for the config slice
`ifndef AGCD_DEFS_VH
`define AGCD_DEFS_VH

// Register indices as printed; byte address is four times the index
`define AGCD_IDX_GAIN        4'h4
`define AGCD_IDX_RSVD        4'h5
`define AGCD_IDX_CFG         4'h6
`define AGCD_IDX_THR_HIGH    4'h7
`define AGCD_IDX_IRQ_STATUS  4'h8
`define AGCD_IDX_IRQ_MASK    4'h9
`define AGCD_IDX_DETECT_STAT 4'hA

// Gain register fields
`define AGCD_GAIN_CH1_HI     6
`define AGCD_GAIN_CH1_LO     4
`define AGCD_GAIN_CH0_HI     2
`define AGCD_GAIN_CH0_LO     0
`define AGCD_GAIN_RESET      16'h0000
`define AGCD_GAIN_WMASK      16'h0077

// Reserved word
`define AGCD_RSVD_RESET      16'h0000

// Configuration register fields
`define AGCD_CFG_RESET       16'h0600
`define AGCD_CFG_WMASK       16'h1FFF
`define AGCD_CFG_DLY_HI      12
`define AGCD_CFG_DLY_LO      9
`define AGCD_CFG_CHOP_EN     8
`define AGCD_CFG_ALLCH       7
`define AGCD_CFG_NUM_HI      6
`define AGCD_CFG_NUM_LO      4
`define AGCD_CFG_LEN_HI      3
`define AGCD_CFG_LEN_LO      1
`define AGCD_CFG_DET_EN      0

// Threshold high word
`define AGCD_THR_RESET       16'h0000

// Interrupt status bits
`define AGCD_IRQ_SETTLED     0
`define AGCD_IRQ_DETECT      1
`define AGCD_IRQ_WINDOW      2
`define AGCD_IRQ_BITS        3

// Detection window lengths, in conversion periods
`define AGCD_LEN_0           12'd128
`define AGCD_LEN_1           12'd256
`define AGCD_LEN_2           12'd512
`define AGCD_LEN_3           12'd768
`define AGCD_LEN_4           12'd1280
`define AGCD_LEN_5           12'd1792
`define AGCD_LEN_6           12'd2560
`define AGCD_LEN_7           12'd3584

// AXI responses
`define AGCD_RESP_OKAY       2'b00
`define AGCD_RESP_SLVERR     2'b10

`endif

// ### rtl/agcd_detect.v
// Current-detect counter: window length, exceedance count and channel qualification
`timescale 1ns/1ps
`include "agcd_defs.vh"

module agcd_detect #(
  parameter NUM_CH = 2
) (
  input  wire              core_clk_in,
  input  wire              reset_n_in,
  input  wire              enable_in,
  input  wire              all_channels_in,
  input  wire [2:0]        trigger_code_in,
  input  wire [2:0]        window_code_in,
  input  wire              conv_tick_in,
  input  wire [NUM_CH-1:0] over_in,
  output reg               detect_pulse_out,
  output reg               window_done_out,
  output reg  [7:0]        hit_count_out
);

  reg  [11:0] conv_cnt_reg;
  reg  [11:0] window_len;
  wire [8:0]  need_hits;
  wire        qualified;

  // Window length lookup, in conversion periods
  always @* begin
    case (window_code_in)
      3'd0:    window_len = `AGCD_LEN_0;
      3'd1:    window_len = `AGCD_LEN_1;
      3'd2:    window_len = `AGCD_LEN_2;
      3'd3:    window_len = `AGCD_LEN_3;
      3'd4:    window_len = `AGCD_LEN_4;
      3'd5:    window_len = `AGCD_LEN_5;
      3'd6:    window_len = `AGCD_LEN_6;
      default: window_len = `AGCD_LEN_7;
    endcase
  end

  // RL10 power-of-two count
  assign need_hits = 9'h001 << trigger_code_in;
  // RL9 any or all qualification
  assign qualified = all_channels_in ? (&over_in) : (|over_in);

  // One detection at most per window; count saturates once it fires
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      conv_cnt_reg     <= 12'h000;
      hit_count_out    <= 8'h00;
      detect_pulse_out <= 1'b0;
      window_done_out  <= 1'b0;
    end else begin
      detect_pulse_out <= 1'b0;
      window_done_out  <= 1'b0;
      if (!enable_in) begin
        conv_cnt_reg  <= 12'h000;
        hit_count_out <= 8'h00;
      end else if (conv_tick_in) begin
        // RL11 window end
        if (conv_cnt_reg == window_len - 12'd1) begin
          conv_cnt_reg    <= 12'h000;
          hit_count_out   <= 8'h00;
          window_done_out <= 1'b1;
        end else begin
          conv_cnt_reg <= conv_cnt_reg + 12'd1;
        end
        if (qualified && ({1'b0, hit_count_out} < need_hits)) begin
          if (conv_cnt_reg != window_len - 12'd1) begin
            hit_count_out <= hit_count_out + 8'd1;
          end
          // RL10 declare detection
          if ({1'b0, hit_count_out} + 9'd1 == need_hits) begin
            detect_pulse_out <= 1'b1;
          end
        end
      end
    end
  end

endmodule

// ### rtl/agcd_regs.v
// Gain, reserved and chop/detect configuration registers behind an AXI4-Lite slave
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "agcd_defs.vh"

//
// Overview of operation
// RL1: Channel-one gain code sits in bits 6:4 of the gain register, codes 0..7 give 1..128, reset 1.
// RL2: Channel-zero gain code sits in bits 2:0 of the gain register, same mapping, reset 1.
// RL3: The host writes zeros to bits 15:10 of the gain register.
// RL4: The host writes zeros to bits 7 and 3 of the gain register.
// RL5: The word at index 5 is all reserved, resets to zero and is only written with zeros.
// RL6: The configuration word at index 6 resets to 0600h with delay code 3 and all else zero.
// RL7: Bits 12:9 pick a chop settling delay of 2 to the power code+1 modulator periods.
// RL8: Bit 8 enables global chop and bit 0 enables current detect, both off after reset.
// RL9: Bit 7 clear means any channel over threshold qualifies, set means all channels must.
// RL10: Bits 6:4 pick 1..128 exceedances needed before a detection is declared.
// RL11: Bits 3:1 pick a detection window of 128..3584 conversion periods.
// RL12: The threshold high sixteen bits live in a separate register at index 7.
//
module agcd_regs #(
  parameter NUM_CH = 2
) (
  input  wire              core_clk_in,
  input  wire              reset_n_in,
  // AXI4-Lite slave
  input  wire [5:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [5:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Converter side
  input  wire              mod_tick_in,
  input  wire              conv_tick_in,
  input  wire              chop_start_in,
  input  wire [NUM_CH-1:0] over_thresh_in,
  output reg  [2:0]        ch0_gain_code_out,
  output reg  [2:0]        ch1_gain_code_out,
  output reg               chop_enable_out,
  output reg               detect_mode_enable_out,
  output reg  [15:0]       detect_threshold_high_out,
  output reg               chop_settled_out,
  output wire              irq_out
);

  // ---------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------
  reg  [15:0] cfg_reg;
  reg  [15:0] rsvd_reg;
  reg  [2:0]  irq_status_reg;
  reg  [2:0]  irq_mask_reg;
  reg  [16:0] chop_cnt_reg;
  reg         chop_busy_reg;
  reg  [5:0]  aw_addr_reg;
  reg         aw_full_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         w_full_reg;

  wire        detect_pulse;
  wire        window_done;
  wire [7:0]  hit_count;
  wire        wr_fire;
  wire [3:0]  wr_idx;
  wire        wr_ok;
  wire [15:0] wr_val;
  wire [3:0]  rd_idx;
  wire [16:0] chop_len;
  wire        chop_done;
  wire [2:0]  irq_events;

  // ---------------------------------------------------------------------
  // Write channel capture, address and data in either order
  // ---------------------------------------------------------------------
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
  assign wr_fire       = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign wr_idx        = aw_addr_reg[5:2];
  // Only the low two byte lanes hold register bits; each user gates on its own strobe
  assign wr_val        = w_data_reg[15:0];

  // Merge helper keeps unstrobed lanes at their old value
  function [15:0] lane_merge;
    input [15:0] old;
    input [15:0] nw;
    input [1:0]  strb;
    begin
      lane_merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  assign wr_ok = (wr_idx == `AGCD_IDX_GAIN) || (wr_idx == `AGCD_IDX_RSVD) ||
                 (wr_idx == `AGCD_IDX_CFG) || (wr_idx == `AGCD_IDX_THR_HIGH) ||
                 (wr_idx == `AGCD_IDX_IRQ_STATUS) || (wr_idx == `AGCD_IDX_IRQ_MASK) ||
                 (wr_idx == `AGCD_IDX_DETECT_STAT);

  // Address and data latches, write response
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_addr_reg  <= 6'h00;
      aw_full_reg  <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      w_full_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AGCD_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_full_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_full_reg <= 1'b1;
      end
      if (wr_fire) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `AGCD_RESP_OKAY : `AGCD_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------
  // Reserved bits are held at zero in storage so a careless write cannot leak
  // into the datapath; the host is still expected to write zeros there.
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // RL1 RL2 gain reset
      ch0_gain_code_out         <= 3'b000;
      ch1_gain_code_out         <= 3'b000;
      // RL5 reserved reset
      rsvd_reg                  <= `AGCD_RSVD_RESET;
      // RL6 config reset
      cfg_reg                   <= `AGCD_CFG_RESET;
      detect_threshold_high_out <= `AGCD_THR_RESET;
      irq_mask_reg              <= 3'b000;
    end else if (wr_fire) begin
      case (wr_idx)
        `AGCD_IDX_GAIN: begin
          // RL1 channel one gain
          if (w_strb_reg[0]) ch1_gain_code_out <= wr_val[`AGCD_GAIN_CH1_HI:`AGCD_GAIN_CH1_LO];
          // RL2 channel zero gain
          if (w_strb_reg[0]) ch0_gain_code_out <= wr_val[`AGCD_GAIN_CH0_HI:`AGCD_GAIN_CH0_LO];
        end
        // RL5 reserved word stays zero
        `AGCD_IDX_RSVD: rsvd_reg <= `AGCD_RSVD_RESET;
        `AGCD_IDX_CFG: begin
          // RL7 RL8 RL9 RL10 RL11 config fields
          cfg_reg <= lane_merge(cfg_reg, wr_val, w_strb_reg[1:0]) & `AGCD_CFG_WMASK;
        end
        `AGCD_IDX_THR_HIGH: begin
          // RL12 threshold high word
          detect_threshold_high_out <= lane_merge(detect_threshold_high_out, wr_val,
                                                  w_strb_reg[1:0]);
        end
        `AGCD_IDX_IRQ_MASK: begin
          if (w_strb_reg[0]) irq_mask_reg <= wr_val[`AGCD_IRQ_BITS-1:0];
        end
        default: begin
          rsvd_reg <= rsvd_reg;
        end
      endcase
    end
  end

  // Field outputs registered from the configuration word
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      chop_enable_out        <= 1'b0;
      detect_mode_enable_out <= 1'b0;
    end else begin
      // RL8 enables
      chop_enable_out        <= cfg_reg[`AGCD_CFG_CHOP_EN];
      detect_mode_enable_out <= cfg_reg[`AGCD_CFG_DET_EN];
    end
  end

  // ---------------------------------------------------------------------
  // Global-chop settling delay
  // ---------------------------------------------------------------------
  // RL7 delay of 2^(code+1)
  assign chop_len  = 17'h0_0002 << cfg_reg[`AGCD_CFG_DLY_HI:`AGCD_CFG_DLY_LO];
  assign chop_done = chop_busy_reg && mod_tick_in && (chop_cnt_reg == chop_len - 17'd1);

  // Counts modulator ticks after each chop phase change; chop_settled_out held low meanwhile
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      chop_cnt_reg     <= 17'h0_0000;
      chop_busy_reg    <= 1'b0;
      chop_settled_out <= 1'b0;
    end else if (!chop_enable_out) begin
      chop_cnt_reg     <= 17'h0_0000;
      chop_busy_reg    <= 1'b0;
      chop_settled_out <= 1'b0;
    end else if (chop_start_in) begin
      chop_cnt_reg     <= 17'h0_0000;
      chop_busy_reg    <= 1'b1;
      chop_settled_out <= 1'b0;
    end else if (chop_done) begin
      chop_busy_reg    <= 1'b0;
      chop_settled_out <= 1'b1;
    end else if (chop_busy_reg && mod_tick_in) begin
      chop_cnt_reg <= chop_cnt_reg + 17'd1;
    end
  end

  // ---------------------------------------------------------------------
  // Current-detect engine
  // ---------------------------------------------------------------------
  agcd_detect #(
    .NUM_CH (NUM_CH)
  ) u_detect (
    .core_clk_in      (core_clk_in),
    .reset_n_in       (reset_n_in),
    .enable_in        (detect_mode_enable_out),
    .all_channels_in  (cfg_reg[`AGCD_CFG_ALLCH]),
    .trigger_code_in  (cfg_reg[`AGCD_CFG_NUM_HI:`AGCD_CFG_NUM_LO]),
    .window_code_in   (cfg_reg[`AGCD_CFG_LEN_HI:`AGCD_CFG_LEN_LO]),
    .conv_tick_in     (conv_tick_in),
    .over_in          (over_thresh_in),
    .detect_pulse_out (detect_pulse),
    .window_done_out  (window_done),
    .hit_count_out    (hit_count)
  );

  // ---------------------------------------------------------------------
  // Interrupts: sticky status, write one to clear, set wins
  // ---------------------------------------------------------------------
  assign irq_events = {window_done, detect_pulse, chop_done};

  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_status_reg <= 3'b000;
    end else begin
      irq_status_reg <= (irq_status_reg &
                         ~((wr_fire && wr_idx == `AGCD_IDX_IRQ_STATUS && w_strb_reg[0]) ?
                           wr_val[`AGCD_IRQ_BITS-1:0] : 3'b000)) | irq_events;
    end
  end

  assign irq_out = |(irq_status_reg & irq_mask_reg);

  // ---------------------------------------------------------------------
  // Read channel, one outstanding read
  // ---------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx        = s_axi_araddr[5:2];

  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AGCD_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `AGCD_RESP_OKAY;
      case (rd_idx)
        `AGCD_IDX_GAIN:        s_axi_rdata <= {25'h0, ch1_gain_code_out, 1'b0,
                                               ch0_gain_code_out};
        `AGCD_IDX_RSVD:        s_axi_rdata <= {16'h0000, rsvd_reg};
        `AGCD_IDX_CFG:         s_axi_rdata <= {16'h0000, cfg_reg};
        `AGCD_IDX_THR_HIGH:    s_axi_rdata <= {16'h0000, detect_threshold_high_out};
        `AGCD_IDX_IRQ_STATUS:  s_axi_rdata <= {29'h0, irq_status_reg};
        `AGCD_IDX_IRQ_MASK:    s_axi_rdata <= {29'h0, irq_mask_reg};
        `AGCD_IDX_DETECT_STAT: s_axi_rdata <= {22'h0, chop_busy_reg, chop_settled_out,
                                               hit_count};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `AGCD_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ### test/agcd_regs_asserts.sv
// Port-level checks for the config register slice
`timescale 1ns/1ps
module agcd_regs_asserts (
  input wire        core_clk_in,
  input wire        reset_n_in,
  input wire [5:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire [5:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        chop_start_in,
  input wire [2:0]  ch0_gain_code_out,
  input wire [2:0]  ch1_gain_code_out,
  input wire        chop_enable_out,
  input wire        detect_mode_enable_out,
  input wire [15:0] detect_threshold_high_out,
  input wire        chop_settled_out
);
  // Full-word write taken in one edge
  wire       wr_go  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                      && (s_axi_wstrb[1:0] == 2'b11);
  wire [3:0] wr_idx = s_axi_awaddr[5:2];
  wire       rd_go  = s_axi_arvalid && s_axi_arready;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_wr_answer;
    wr_go |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("no write response");

  property p_ch1_gain;
    logic [2:0] g;
    (wr_go && wr_idx == 4'h4, g = s_axi_wdata[6:4]) |-> ##2 ch1_gain_code_out == g;
  endproperty
  a_ch1_gain: assert property (p_ch1_gain)
    else $error("ch1 gain wrong");

  property p_ch0_gain;
    logic [2:0] g;
    (wr_go && wr_idx == 4'h4, g = s_axi_wdata[2:0]) |-> ##2 ch0_gain_code_out == g;
  endproperty
  a_ch0_gain: assert property (p_ch0_gain)
    else $error("ch0 gain wrong");

  property p_rsvd_read;
    rd_go && s_axi_araddr[5:2] == 4'h5 |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved nonzero");

  property p_reset_state;
    $rose(reset_n_in) |-> !chop_enable_out && !detect_mode_enable_out
                          && ch0_gain_code_out == 3'h0 && ch1_gain_code_out == 3'h0;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("bad reset state");

  property p_settle_clear;
    chop_start_in |=> !chop_settled_out;
  endproperty
  a_settle_clear: assert property (p_settle_clear)
    else $error("settled not cleared");

  property p_chop_en;
    logic b;
    (wr_go && wr_idx == 4'h6, b = s_axi_wdata[8]) |-> ##3 chop_enable_out == b;
  endproperty
  a_chop_en: assert property (p_chop_en)
    else $error("chop enable wrong");

  property p_det_en;
    logic b;
    (wr_go && wr_idx == 4'h6, b = s_axi_wdata[0]) |-> ##3 detect_mode_enable_out == b;
  endproperty
  a_det_en: assert property (p_det_en)
    else $error("detect enable wrong");

  property p_thr;
    logic [15:0] t;
    (wr_go && wr_idx == 4'h7, t = s_axi_wdata[15:0]) |-> ##2 detect_threshold_high_out == t;
  endproperty
  a_thr: assert property (p_thr)
    else $error("threshold wrong");

  c_cfg_write: cover property (wr_go && wr_idx == 4'h6);
  c_settled:   cover property ($rose(chop_settled_out));
  c_rsvd_read: cover property (rd_go && s_axi_araddr[5:2] == 4'h5);
endmodule

bind agcd_regs agcd_regs_asserts u_chk (
  .core_clk_in, .reset_n_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .chop_start_in, .ch0_gain_code_out,
  .ch1_gain_code_out, .chop_enable_out, .detect_mode_enable_out, .detect_threshold_high_out,
  .chop_settled_out
);

// ### test/agcd_host.sv
// Host model: AXI4-Lite master for the configuration words
`timescale 1ns/1ps
module agcd_host (
  input  wire         core_clk_in,
  output logic [5:0]  s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  wire         s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  wire         s_axi_wready,
  input  wire [1:0]   s_axi_bresp,
  input  wire         s_axi_bvalid,
  output logic        s_axi_bready,
  output logic [5:0]  s_axi_araddr,
  output logic        s_axi_arvalid,
  input  wire         s_axi_arready,
  input  wire [31:0]  s_axi_rdata,
  input  wire [1:0]   s_axi_rresp,
  input  wire         s_axi_rvalid,
  output logic        s_axi_rready,
  output logic        hung_out
);
  // Idle bus from time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 16'h0000;
    s_axi_wdata = 32'h0000_0000;
    hung_out = 1'b0;
  end

  // One write; a stuck slave raises hung_out
  task automatic wr(input logic [3:0] idx, input logic [15:0] d, output logic [1:0] resp);
    int n;
    begin
      n = 0;
      @(posedge core_clk_in);
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_wdata   <= {16'h0000, idx == 4'h5 ? 16'h0000 : idx == 4'h4 ? d & 16'h0077 : d};
      s_axi_wstrb   <= 4'h3;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
        @(posedge core_clk_in);
        n++;
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 99);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (!s_axi_bvalid) hung_out <= 1'b1;
    end
  endtask

  // One read, answer taken at the rvalid edge
  task automatic rd(input logic [3:0] idx, output logic [31:0] d, output logic [1:0] resp);
    int n;
    begin
      n = 0;
      @(posedge core_clk_in);
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
        @(posedge core_clk_in);
        n++;
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 99);
      d = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (!s_axi_rvalid) hung_out <= 1'b1;
    end
  endtask
endmodule

// ### test/tb_adc_gain_chop_detect_cfg.sv
// Self-checking bench for the configuration slice
`timescale 1ns/1ps
module tb_adc_gain_chop_detect_cfg;
  typedef struct packed {
    logic [3:0]  idx;
    logic [15:0] d;
    logic [15:0] q;
    logic [1:0]  rsp;
  } agcd_row_t;
  logic        core_clk_in, reset_n_in, mod_tick_in, conv_tick_in, chop_start_in, hung;
  logic [1:0]  over_thresh_in, s_axi_bresp, s_axi_rresp, rsp;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0]  ch0_gain_code_out, ch1_gain_code_out;
  logic        chop_enable_out, detect_mode_enable_out, chop_settled_out, irq_out;
  logic [15:0] detect_threshold_high_out;
  agcd_row_t   r;
  int          fails, n_checks;
  agcd_row_t   rows [15] = '{
    '{4'h4, 16'h0007, 16'h0007, 2'b00}, '{4'h4, 16'h0016, 16'h0016, 2'b00},
    '{4'h4, 16'h0025, 16'h0025, 2'b00}, '{4'h4, 16'h0034, 16'h0034, 2'b00},
    '{4'h4, 16'h0043, 16'h0043, 2'b00}, '{4'h4, 16'h0052, 16'h0052, 2'b00},
    '{4'h4, 16'h0061, 16'h0061, 2'b00}, '{4'h4, 16'h0070, 16'h0070, 2'b00},
    '{4'h6, 16'h1FFF, 16'h1FFF, 2'b00}, '{4'h6, 16'h0AAA, 16'h0AAA, 2'b00},
    '{4'h6, 16'h1555, 16'h1555, 2'b00}, '{4'h6, 16'h0600, 16'h0600, 2'b00},
    '{4'h7, 16'hA55A, 16'hA55A, 2'b00}, '{4'h5, 16'h0000, 16'h0000, 2'b00},
    '{4'hB, 16'h1234, 16'h0000, 2'b10}};

  agcd_regs dut (.core_clk_in, .reset_n_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .mod_tick_in, .conv_tick_in, .chop_start_in, .over_thresh_in,
    .ch0_gain_code_out, .ch1_gain_code_out, .chop_enable_out, .detect_mode_enable_out,
    .detect_threshold_high_out, .chop_settled_out, .irq_out);
  agcd_host host (.core_clk_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .hung_out(hung));

  // 250 MHz clock
  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end

  task automatic test_done;
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Pulse one tick source k times
  task automatic pulse(input int which, input int k);
    repeat (k) begin
      @(posedge core_clk_in);
      {chop_start_in, conv_tick_in, mod_tick_in} <= 3'(1 << which);
      @(posedge core_clk_in);
      {chop_start_in, conv_tick_in, mod_tick_in} <= 3'h0;
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic [15:0] d);
    host.wr(idx, d, rsp);
    chk("bresp", 32'(2'b00), 32'(rsp));
  endtask

  // A stuck handshake ends the run as a failure
  always @(posedge hung) begin
    fails++;
    test_done();
  end

  initial begin
    {reset_n_in, mod_tick_in, conv_tick_in, chop_start_in} = 4'h0;
    over_thresh_in = 2'b00;
    fails = 0;
    n_checks = 0;
    repeat (6) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    // Table rows: write, read back, check fields
    foreach (rows[i]) begin
      r = rows[i];
      host.wr(r.idx, r.d, rsp);
      chk("bresp", 32'(r.rsp), 32'(rsp));
      host.rd(r.idx, rv, rsp);
      chk("rresp", 32'(r.rsp), 32'(rsp));
      chk("rdata", 32'(r.q), rv);
      if (r.idx == 4'h4)
        chk("gain", 32'(r.d[6:0]), 32'({ch1_gain_code_out, 1'b0, ch0_gain_code_out}));
      if (r.idx == 4'h6)
        chk("en", 32'({r.d[8], r.d[0]}), 32'({chop_enable_out, detect_mode_enable_out}));
      if (r.idx == 4'h7) chk("thr", 32'(r.d), 32'(detect_threshold_high_out));
    end
    // Mid-run reset restores defaults
    reset_n_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    for (int i = 4; i < 8; i++) begin
      host.rd(4'(i), rv, rsp);
      chk("reset word", i == 6 ? 32'h0000_0600 : 32'h0000_0000, rv);
    end
    // Settling delay at codes 0 and 3, then irq mask and clear
    for (int c = 0; c < 4; c += 3) begin
      wr(4'h6, 16'(16'h0100 | (c << 9)));
      wr(4'h8, 16'h0007);
      pulse(2, 1);
      pulse(0, (2 << c) - 1);
      chk("early settle", 32'h0, 32'(chop_settled_out));
      pulse(0, 1);
      repeat (2) @(posedge core_clk_in);
      chk("settled", 32'h1, 32'(chop_settled_out));
      wr(4'h9, 16'h0001);
      chk("irq on", 32'h1, 32'(irq_out));
      wr(4'h9, 16'h0000);
      chk("irq masked", 32'h0, 32'(irq_out));
      wr(4'h9, 16'h0001);
      wr(4'h8, 16'h0001);
      chk("irq cleared", 32'h0, 32'(irq_out));
    end
    // All-channel mode, two hits needed, 128-tick window
    wr(4'h6, 16'h0091);
    wr(4'h8, 16'h0007);
    over_thresh_in <= 2'b01;
    pulse(1, 3);
    host.rd(4'hA, rv, rsp);
    chk("hits one ch", 32'h0, 32'(rv[7:0]));
    over_thresh_in <= 2'b11;
    pulse(1, 1);
    host.rd(4'h8, rv, rsp);
    chk("status one hit", 32'h0, 32'(rv[2:0]));
    pulse(1, 1);
    host.rd(4'h8, rv, rsp);
    chk("status detect", 32'h2, 32'(rv[2:0]));
    over_thresh_in <= 2'b00;
    pulse(1, 122);
    host.rd(4'h8, rv, rsp);
    chk("status 127", 32'h2, 32'(rv[2:0]));
    pulse(1, 1);
    host.rd(4'h8, rv, rsp);
    chk("status window", 32'h6, 32'(rv[2:0]));
    // Any-channel mode counts a single channel
    wr(4'h6, 16'h0011);
    over_thresh_in <= 2'b01;
    pulse(1, 1);
    host.rd(4'hA, rv, rsp);
    chk("hits any ch", 32'h1, 32'(rv[7:0]));
    test_done();
  end
endmodule
